//--- uart_cfg_pkg.sv
// Constants for the enhanced UART configuration block.
// Assumes a 16550-style 3-bit register address and one-cycle strobes.
// ====================
// Notes on behaviour
// [R1] Feature bit 4 disables transmitter when unlocked
// [R2] Feature bit 5 disables receiver when unlocked
// [R3] Feature bit 6 selects 9-bit multidrop
// [R4] Feature bit 7 selects fast infrared pulse
// [R5] Scratch register resets to all ones
// [R6] Swap set: scratch writes hit mode register
// [R7] Swap set: scratch reads give FIFO counts
// [R8] Alternate mode: RX first, then toggle
// [R9] Send-immediate bypasses FIFO, clears after send
// [R10] Invert bit flips RS-485 direction level
// [R11] Four-bit code maps to RTS hysteresis
// [R12] Mode bit 6 picks line-error interrupt timing
// [R13] Mode bit 7 limits Xoff/special clearing
// [R14] XON interrupt clears only on source read
// [R15] Divisor is bytes plus fraction over 16
// [R16] Fraction register needs unlock bit
// [R17] Sampling bits pick 16X, 8X, 4X
// [R18] Select bits steer divisor writes
// [R19] Host keeps select bit 7 low when shared
// [R20] Trigger register writes RX or TX level
// [R21] FIFO count readable via swap or 0xBF
// [R22] Trigger-select bit picks counted FIFO
// [R23] Mode and feature bits reset to zero
package uart_cfg_pkg;

  // ====================
  // Register addresses
  localparam logic [2:0] ADDR_DATA     = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_FRAC     = 3'h2;
  localparam logic [2:0] ADDR_ISRC     = 3'h2;
  localparam logic [2:0] ADDR_LCTRL    = 3'h3;
  localparam logic [2:0] ADDR_FEATURE  = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH  = 3'h7;
  localparam logic [2:0] ADDR_FSC      = 3'h1;
  localparam logic [2:0] ADDR_UNLOCK   = 3'h2;

  // ====================
  // Access keys and reset values
  localparam logic [7:0] LCR_ENH_KEY    = 8'hbf;
  localparam int         LCR_DLAB_BIT   = 7;
  localparam logic [7:0] SCRATCH_RESET  = 8'hff;
  localparam logic [7:0] ZERO_RESET     = 8'h00;
  localparam logic [7:0] DIV_LOW_RESET  = 8'h01;

  // ====================
  // Field positions
  localparam int UNLOCK_BIT      = 4;
  localparam int FEAT_TX_DIS     = 4;
  localparam int FEAT_RX_DIS     = 5;
  localparam int FEAT_NINE_BIT   = 6;
  localparam int FEAT_FAST_IR    = 7;
  localparam int FSC_AUTO485     = 3;
  localparam int FSC_SWAP        = 6;
  localparam int FSC_TRIG_SEL    = 7;
  localparam int MODE_SEND_NOW   = 2;
  localparam int MODE_RTS_INV    = 3;
  localparam int MODE_LSR_IMMED  = 6;
  localparam int MODE_ISR_ONLY   = 7;
  localparam int FRAC_INDEP      = 6;
  localparam int FRAC_SELECT     = 7;

  // Hysteresis characters per four-bit code
  localparam logic [5:0] HYST_TABLE [16] = '{
    6'd0,  6'd4,  6'd6,  6'd8,  6'd8,  6'd16, 6'd24, 6'd32,
    6'd40, 6'd44, 6'd48, 6'd52, 6'd12, 6'd20, 6'd28, 6'd36};

  typedef enum logic [1:0] {
    CNT_RX,
    CNT_TX,
    CNT_ALT
  } count_mode_t;

endpackage

//--- uart_enh_cfg.sv
// Enhanced configuration registers of a 16550-style UART.
// Assumes the bus strobes, FIFO levels and shifter events come from logic on clk_sys_i.
module uart_enh_cfg
  import uart_cfg_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic       fifo_enabled_i,
  input  wire logic [7:0] rx_fifo_level_i,
  input  wire logic [7:0] tx_fifo_level_i,
  input  wire logic       tx_byte_sent_i,
  input  wire logic       tx_active_i,
  input  wire logic       err_fifo_entry_i,
  input  wire logic       err_at_rhr_i,
  input  wire logic       xoff_seen_i,
  input  wire logic       xon_seen_i,
  input  wire logic       special_seen_i,
  input  wire logic       char_seen_i,
  output logic            tx_disable_o,
  output logic            rx_disable_o,
  output logic            nine_bit_o,
  output logic            fast_ir_o,
  output logic            tx_direct_load_o,
  output logic            send_pending_o,
  output logic            rs485_dir_o,
  output logic      [5:0] rts_hyst_o,
  output logic            line_err_irq_o,
  output logic            xoff_irq_o,
  output logic            xon_irq_o,
  output logic            special_irq_o,
  output logic     [15:0] tx_divisor_o,
  output logic      [3:0] tx_fraction_o,
  output logic      [1:0] tx_sampling_o,
  output logic     [15:0] rx_divisor_o,
  output logic      [3:0] rx_fraction_o,
  output logic      [1:0] rx_sampling_o,
  output logic      [7:0] rx_trigger_o,
  output logic      [7:0] tx_trigger_o
);

  // ====================
  // Decoding
  logic [7:0] line_control;
  logic [7:0] enhanced_unlock;
  logic [7:0] feature_select_control;
  logic [7:0] extended_feature_control;
  logic [7:0] scratch_storage;
  logic [7:0] enhanced_mode_select;
  logic [7:0] divisor_fraction_sampling;
  logic       alt_show_tx;
  logic       enh_page;
  logic       dlab_page;
  logic       unlocked;
  logic       swap;

  assign enh_page  = (line_control == LCR_ENH_KEY);
  assign dlab_page = line_control[LCR_DLAB_BIT] && !enh_page;
  assign unlocked  = enhanced_unlock[UNLOCK_BIT];
  assign swap      = feature_select_control[FSC_SWAP];

  function automatic logic hit(input logic [2:0] a, input logic [2:0] want,
                               input logic page);
    hit = (a == want) && page;
  endfunction

  function automatic count_mode_t count_mode(input logic [1:0] bits);
    if (!bits[0]) begin
      count_mode = CNT_RX;
    end else if (!bits[1]) begin
      count_mode = CNT_TX;
    end else begin
      count_mode = CNT_ALT;
    end
  endfunction

  logic wr_lctrl, wr_unlock, wr_fsc, wr_feature, wr_scratch, wr_mode;
  logic wr_div_low, wr_div_high, wr_frac, wr_trg, wr_thr;
  logic rd_swap_count, rd_key_count, rd_isrc;

  assign wr_lctrl    = ce_i && wr_i && (addr_i == ADDR_LCTRL);
  assign wr_unlock   = ce_i && wr_i && hit(addr_i, ADDR_UNLOCK, enh_page);
  assign wr_fsc      = ce_i && wr_i && hit(addr_i, ADDR_FSC, enh_page);
  assign wr_trg      = ce_i && wr_i && hit(addr_i, ADDR_DATA, enh_page);
  assign wr_div_low  = ce_i && wr_i && hit(addr_i, ADDR_DATA, dlab_page);
  assign wr_div_high = ce_i && wr_i && hit(addr_i, ADDR_DIV_HIGH, dlab_page);
  // Fraction register hidden until unlock bit is set
  assign wr_frac     = ce_i && wr_i && hit(addr_i, ADDR_FRAC, dlab_page) && unlocked; // [R16]
  assign wr_thr      = ce_i && wr_i && hit(addr_i, ADDR_DATA, !line_control[LCR_DLAB_BIT]);
  assign wr_feature  = ce_i && wr_i && (addr_i == ADDR_FEATURE) && unlocked;
  assign wr_scratch  = ce_i && wr_i && (addr_i == ADDR_SCRATCH) && !swap;
  assign wr_mode     = ce_i && wr_i && (addr_i == ADDR_SCRATCH) && swap; // [R6]
  assign rd_swap_count = ce_i && rd_i && (addr_i == ADDR_SCRATCH) && swap;
  assign rd_key_count  = ce_i && rd_i && hit(addr_i, ADDR_DATA, enh_page);
  assign rd_isrc       = ce_i && rd_i && hit(addr_i, ADDR_ISRC, !line_control[LCR_DLAB_BIT]);

  // ====================
  // Page and unlock registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      line_control <= ZERO_RESET;
    end else if (wr_lctrl) begin
      line_control <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      enhanced_unlock        <= ZERO_RESET;
      feature_select_control <= ZERO_RESET;
    end else begin
      if (wr_unlock) begin
        enhanced_unlock <= wdata_i;
      end
      if (wr_fsc) begin
        feature_select_control <= wdata_i;
      end
    end
  end

  // ====================
  // Extended feature control, write-only, upper nibble
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      extended_feature_control <= ZERO_RESET; // [R23]
    end else if (wr_feature) begin
      extended_feature_control <= {wdata_i[7:4], 4'h0}; // [R1] [R2] [R3] [R4]
    end
  end

  assign tx_disable_o = extended_feature_control[FEAT_TX_DIS]; // [R1]
  assign rx_disable_o = extended_feature_control[FEAT_RX_DIS]; // [R2]
  assign nine_bit_o   = extended_feature_control[FEAT_NINE_BIT]; // [R3]
  assign fast_ir_o    = extended_feature_control[FEAT_FAST_IR]; // [R4]

  // ====================
  // Scratch storage; survives sleep because only reset and scratch writes touch it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scratch_storage <= SCRATCH_RESET; // [R5]
    end else if (wr_scratch) begin
      scratch_storage <= wdata_i; // [R5]
    end
  end

  // ====================
  // Enhanced mode select; bit 2 is cleared by the shifter
  logic direct_loaded;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      enhanced_mode_select <= ZERO_RESET; // [R23]
    end else if (wr_mode) begin
      // A fresh write wins over a same-cycle completion
      enhanced_mode_select <= wdata_i; // [R6]
    end else if (ce_i && tx_byte_sent_i && direct_loaded) begin
      enhanced_mode_select[MODE_SEND_NOW] <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      direct_loaded <= 1'b0;
    end else if (wr_mode) begin
      direct_loaded <= 1'b0;
    end else if (tx_direct_load_o) begin
      direct_loaded <= 1'b1; // [R9]
    end else if (ce_i && tx_byte_sent_i) begin
      direct_loaded <= 1'b0;
    end
  end

  // Only the first byte after arming goes straight to the shifter
  assign tx_direct_load_o = wr_thr && fifo_enabled_i && !direct_loaded
                            && enhanced_mode_select[MODE_SEND_NOW]; // [R9]
  assign send_pending_o   = enhanced_mode_select[MODE_SEND_NOW];

  // ====================
  // RS-485 direction and hysteresis
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rs485_dir_o <= 1'b0;
      rts_hyst_o  <= HYST_TABLE[0];
    end else if (ce_i) begin
      if (feature_select_control[FSC_AUTO485]) begin
        rs485_dir_o <= !tx_active_i ^ enhanced_mode_select[MODE_RTS_INV]; // [R10]
      end else begin
        rs485_dir_o <= 1'b0;
      end
      rts_hyst_o <= HYST_TABLE[{enhanced_mode_select[5:4],
                                feature_select_control[1:0]}]; // [R11]
    end
  end

  // ====================
  // Interrupt timing and clearing
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      line_err_irq_o <= 1'b0;
    end else if (ce_i) begin
      line_err_irq_o <= enhanced_mode_select[MODE_LSR_IMMED] ? err_fifo_entry_i
                                                             : err_at_rhr_i; // [R12]
    end
  end

  logic isr_only;
  assign isr_only = enhanced_mode_select[MODE_ISR_ONLY];

  // Each flag: a new event in the clearing cycle wins
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      xoff_irq_o    <= 1'b0;
      xon_irq_o     <= 1'b0;
      special_irq_o <= 1'b0;
    end else if (ce_i) begin
      if (xoff_seen_i) begin
        xoff_irq_o <= 1'b1;
      end else if (rd_isrc || (!isr_only && xon_seen_i)) begin
        xoff_irq_o <= 1'b0; // [R13]
      end
      if (xon_seen_i) begin
        xon_irq_o <= 1'b1;
      end else if (rd_isrc) begin
        xon_irq_o <= 1'b0; // [R14]
      end
      if (special_seen_i) begin
        special_irq_o <= 1'b1;
      end else if (rd_isrc || (!isr_only && char_seen_i)) begin
        special_irq_o <= 1'b0; // [R13]
      end
    end
  end

  // ====================
  // Baud divisors
  logic [7:0] tx_low, tx_high, rx_low, rx_high;
  logic [5:0] tx_frac_bits, rx_frac_bits;
  logic       to_tx, to_rx;

  // Select 10 leaves both generators untouched
  always_comb begin
    case (divisor_fraction_sampling[FRAC_SELECT:FRAC_INDEP])
      2'b00: begin
        to_tx = 1'b1;
        to_rx = 1'b1;
      end
      2'b01: begin
        to_tx = 1'b1;
        to_rx = 1'b0;
      end
      2'b11: begin
        to_tx = 1'b0;
        to_rx = 1'b1;
      end
      default: begin
        to_tx = 1'b0; // [R19]
        to_rx = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      divisor_fraction_sampling <= ZERO_RESET; // [R23]
    end else if (wr_frac) begin
      divisor_fraction_sampling <= wdata_i;
    end
  end

  // Steering follows the select bits being written in the same access
  logic [1:0] new_sel;
  logic       frac_tx, frac_rx;
  assign new_sel = wdata_i[FRAC_SELECT:FRAC_INDEP];
  assign frac_tx = (new_sel == 2'b00) || (new_sel == 2'b01);
  assign frac_rx = (new_sel == 2'b00) || (new_sel == 2'b11);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_low       <= DIV_LOW_RESET;
      tx_high      <= ZERO_RESET;
      tx_frac_bits <= 6'h00;
    end else begin
      if (wr_div_low && to_tx) begin
        tx_low <= wdata_i; // [R18]
      end
      if (wr_div_high && to_tx) begin
        tx_high <= wdata_i; // [R18]
      end
      if (wr_frac && frac_tx) begin
        tx_frac_bits <= wdata_i[5:0]; // [R18]
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rx_low       <= DIV_LOW_RESET;
      rx_high      <= ZERO_RESET;
      rx_frac_bits <= 6'h00;
    end else begin
      if (wr_div_low && to_rx) begin
        rx_low <= wdata_i; // [R18]
      end
      if (wr_div_high && to_rx) begin
        rx_high <= wdata_i; // [R18]
      end
      if (wr_frac && frac_rx) begin
        rx_frac_bits <= wdata_i[5:0]; // [R18]
      end
    end
  end

  // Generator runs at divisor + fraction/16 of the sampling clock
  assign tx_divisor_o  = {tx_high, tx_low}; // [R15]
  assign tx_fraction_o = tx_frac_bits[3:0]; // [R15]
  assign rx_divisor_o  = {rx_high, rx_low}; // [R15]
  assign rx_fraction_o = rx_frac_bits[3:0]; // [R15]

  // 00 is 16X, 01 is 8X, 1x is 4X
  function automatic logic [1:0] sampling(input logic [1:0] bits);
    sampling = bits[1] ? 2'b10 : bits;
  endfunction

  assign tx_sampling_o = sampling(tx_frac_bits[5:4]); // [R17]
  assign rx_sampling_o = sampling(rx_frac_bits[5:4]); // [R17]

  // ====================
  // User trigger levels
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rx_trigger_o <= ZERO_RESET;
      tx_trigger_o <= ZERO_RESET;
    end else if (wr_trg) begin
      if (feature_select_control[FSC_TRIG_SEL]) begin
        tx_trigger_o <= wdata_i; // [R20]
      end else begin
        rx_trigger_o <= wdata_i; // [R20]
      end
    end
  end

  // ====================
  // FIFO count alternation
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      alt_show_tx <= 1'b0;
    end else if (wr_mode) begin
      alt_show_tx <= 1'b0; // [R8]
    end else if (rd_swap_count && count_mode(enhanced_mode_select[1:0]) == CNT_ALT) begin
      alt_show_tx <= !alt_show_tx; // [R8]
    end
  end

  // ====================
  // Read data, registered one cycle after rd_i
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = ZERO_RESET;
    if (rd_swap_count) begin
      case (count_mode(enhanced_mode_select[1:0]))
        CNT_RX:  next_rdata = rx_fifo_level_i; // [R7]
        CNT_TX:  next_rdata = tx_fifo_level_i; // [R7]
        CNT_ALT: next_rdata = alt_show_tx ? tx_fifo_level_i : rx_fifo_level_i; // [R8]
        default: next_rdata = rx_fifo_level_i;
      endcase
    end else if (rd_key_count) begin
      next_rdata = feature_select_control[FSC_TRIG_SEL] ? tx_fifo_level_i
                                                        : rx_fifo_level_i; // [R21] [R22]
    end else if (ce_i && rd_i) begin
      case (addr_i)
        ADDR_SCRATCH: next_rdata = scratch_storage; // [R7]
        ADDR_LCTRL:   next_rdata = line_control;
        ADDR_FSC: begin
          if (enh_page) begin
            next_rdata = feature_select_control;
          end else if (dlab_page) begin
            next_rdata = divisor_fraction_sampling[FRAC_SELECT] ? rx_high : tx_high;
          end
        end
        ADDR_FRAC: begin
          if (enh_page) begin
            next_rdata = enhanced_unlock;
          end else if (dlab_page && unlocked) begin
            next_rdata = {divisor_fraction_sampling[7:6],
                          divisor_fraction_sampling[FRAC_SELECT] ? rx_frac_bits
                                                                 : tx_frac_bits};
          end
        end
        ADDR_DATA: begin
          if (dlab_page) begin
            next_rdata = divisor_fraction_sampling[FRAC_SELECT] ? rx_low : tx_low;
          end
        end
        default: next_rdata = ZERO_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= ZERO_RESET;
    end else if (ce_i && rd_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule

//--- uart_enh_cfg_sva.sv
// Port assertions for the UART configuration block.
// Assumes one clock, rst_i async active high.
module uart_enh_cfg_chk
  import uart_cfg_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic  [2:0] addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic  [7:0] rdata_o,
  input wire logic        fifo_enabled_i,
  input wire logic        tx_byte_sent_i,
  input wire logic        err_fifo_entry_i,
  input wire logic        err_at_rhr_i,
  input wire logic        xoff_seen_i,
  input wire logic        xon_seen_i,
  input wire logic        char_seen_i,
  input wire logic        tx_direct_load_o,
  input wire logic        send_pending_o,
  input wire logic        line_err_irq_o,
  input wire logic        xoff_irq_o,
  input wire logic        xon_irq_o,
  input wire logic        special_irq_o,
  input wire logic [15:0] tx_divisor_o,
  input wire logic [15:0] rx_divisor_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // ====================
  // Sequences
  sequence xon_arrives;
    ce_i && xon_seen_i;
  endsequence
  // A direct load followed by a cycle with no re-arm and no completion
  sequence load_then_idle;
    tx_direct_load_o ##1 !(ce_i && (tx_byte_sent_i || (wr_i && addr_i == ADDR_SCRATCH)));
  endsequence

  // ====================
  // Assertions
  AST_XON_SET: assert property (xon_arrives |=> xon_irq_o)
    else $error("xon not set");
  AST_XON_HOLD: assert property (
    xon_irq_o && !(ce_i && rd_i && addr_i == ADDR_ISRC) |=> xon_irq_o)
    else $error("xon lost");
  AST_XOFF_HOLD: assert property (
    xoff_irq_o && !(ce_i && ((rd_i && addr_i == ADDR_ISRC) || xon_seen_i)) |=> xoff_irq_o)
    else $error("xoff lost");
  AST_SPECIAL_HOLD: assert property (
    special_irq_o && !(ce_i && ((rd_i && addr_i == ADDR_ISRC) || char_seen_i))
    |=> special_irq_o)
    else $error("special lost");
  AST_DIRECT_LOAD: assert property (
    tx_direct_load_o |-> ce_i && wr_i && addr_i == ADDR_DATA && fifo_enabled_i && send_pending_o)
    else $error("bad direct load");
  AST_ONE_SHOT: assert property (load_then_idle |-> !tx_direct_load_o)
    else $error("double direct load");
  AST_SEND_CLEAR: assert property (
    $fell(send_pending_o) |-> $past(ce_i && (tx_byte_sent_i || wr_i)))
    else $error("pending lost");
  AST_LINE_ERR: assert property (
    $rose(line_err_irq_o) |-> $past(err_fifo_entry_i || err_at_rhr_i))
    else $error("stray line error");
  AST_RDATA_HOLD: assert property (!(ce_i && rd_i) |=> $stable(rdata_o))
    else $error("rdata moved");
  AST_DIV_WRITE: assert property (
    $changed(tx_divisor_o) || $changed(rx_divisor_o) |-> $past(ce_i && wr_i))
    else $error("stray divisor change");
endmodule

bind uart_enh_cfg uart_enh_cfg_chk chk_u (.*);

//--- host_bus_model.sv
// Host model on the parallel register bus.
// Assumes requests launch 1 ns after a rising edge.
module host_bus_model (
  input  wire logic       clk_sys_i,
  output logic            ce_o,
  output logic      [2:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {ce_o, addr_o, wr_o, rd_o, wdata_o} = {1'b1, 13'h0};
  end

  // One strobe per access; released data is inverted, never left stale
  task automatic access(input logic [2:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_sys_i);
    #1;
    {wr_o, rd_o} = 2'b00;
    wdata_o = ~d;
    addr_o = ~a;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the UART configuration block.
// Assumes host_bus_model and the bound checker.
module testbench
  import uart_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys_i, rst_i, ce_i, wr_i, rd_i, fifo_enabled_i, tx_byte_sent_i, tx_active_i;
  logic        err_fifo_entry_i, err_at_rhr_i, xoff_seen_i, xon_seen_i, special_seen_i;
  logic        char_seen_i, tx_disable_o, rx_disable_o, nine_bit_o, fast_ir_o;
  logic        tx_direct_load_o, send_pending_o, rs485_dir_o, line_err_irq_o;
  logic        xoff_irq_o, xon_irq_o, special_irq_o;
  logic  [2:0] addr_i;
  logic  [7:0] wdata_i, rdata_o, rx_fifo_level_i, tx_fifo_level_i, rx_trigger_o, tx_trigger_o;
  logic  [5:0] rts_hyst_o;
  logic [15:0] tx_divisor_o, rx_divisor_o, tdiv, rdiv, d;
  logic  [3:0] tx_fraction_o, rx_fraction_o, tfr, rfr, f;
  logic  [1:0] tx_sampling_o, rx_sampling_o, ts, rs, e;
  logic  [1:0] sels [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic  [7:0] exp_q [$];
  int          hyst_tbl [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
  int          miscompares, checked, cycles, loads;
  int          seed = 32'hb770;

  uart_enh_cfg dut_u (.*);
  host_bus_model hb (.clk_sys_i, .ce_o(ce_i), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
    .wdata_o(wdata_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ====================
  // Compare, report and bus helpers
  task automatic chk(input string what, input logic [15:0] ex, input logic [15:0] got);
    checked++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic wrap_up();
    // Lets the last read compare land first
    #5;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    hb.access(a, v, 1'b1);
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] ex);
    exp_q.push_back(ex);
    hb.access(a, 8'h00, 1'b0);
  endtask
  // Writes one register of the 0xBF page, then returns to the normal page
  task automatic enh(input logic [2:0] a, input logic [7:0] v);
    wr_reg(ADDR_LCTRL, 8'hbf);
    wr_reg(a, v);
    wr_reg(ADDR_LCTRL, 8'h00);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk_sys_i);
    #1;
    s = 1'b1;
    @(posedge clk_sys_i);
    #1;
    s = 1'b0;
  endtask
  task automatic check_reset();
    chk("tx_div", 16'h0001, tx_divisor_o);
    chk("rx_div", 16'h0001, rx_divisor_o);
    chk("cfg", 16'h0, 16'({tx_disable_o, rx_disable_o, nine_bit_o, fast_ir_o, send_pending_o,
      tx_sampling_o, rx_sampling_o}));
    rd_reg(ADDR_SCRATCH, 8'hff);
  endtask

  // ====================
  // Read result monitor, load counter and hang guard
  always @(posedge clk_sys_i) begin
    if (ce_i && rd_i && exp_q.size() > 0) begin
      #2;
      chk("rdata_o", 16'(exp_q.pop_front()), 16'(rdata_o));
    end
  end
  always @(posedge clk_sys_i) begin
    if (tx_direct_load_o === 1'b1) loads++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ====================
  // Main sequence
  initial begin
    {rst_i, fifo_enabled_i, tx_byte_sent_i, tx_active_i, err_fifo_entry_i, err_at_rhr_i,
      xoff_seen_i, xon_seen_i, special_seen_i, char_seen_i} = 10'h300;
    {tdiv, rdiv, tfr, rfr, ts, rs} = {16'h0001, 16'h0001, 12'h0};
    rx_fifo_level_i = 8'($random(seed));
    tx_fifo_level_i = 8'($random(seed));
    repeat (16) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check_reset();
    wr_reg(ADDR_FEATURE, 8'hf0);
    chk("feat_locked", 16'h0, 16'({fast_ir_o, nine_bit_o, rx_disable_o, tx_disable_o}));
    enh(ADDR_UNLOCK, 8'h10);
    for (int i = 4; i < 8; i++) begin
      wr_reg(ADDR_FEATURE, 8'(1 << i));
      chk("feat", 16'(1 << (i - 4)), 16'({fast_ir_o, nine_bit_o, rx_disable_o, tx_disable_o}));
    end
    d = 16'($random(seed));
    wr_reg(ADDR_SCRATCH, d[7:0]);
    hb.ce_o = 1'b0;
    wr_reg(ADDR_SCRATCH, ~d[7:0]);
    hb.ce_o = 1'b1;
    rd_reg(ADDR_SCRATCH, d[7:0]);
    rd_reg(3'h4, 8'h00);
    enh(ADDR_FSC, 8'h40);
    wr_reg(ADDR_SCRATCH, 8'h02);
    rd_reg(ADDR_SCRATCH, rx_fifo_level_i);
    wr_reg(ADDR_SCRATCH, 8'h01);
    rd_reg(ADDR_SCRATCH, tx_fifo_level_i);
    wr_reg(ADDR_SCRATCH, 8'h03);
    for (int i = 0; i < 3; i++) rd_reg(ADDR_SCRATCH, i[0] ? tx_fifo_level_i : rx_fifo_level_i);
    enh(ADDR_FSC, 8'h00);
    rd_reg(ADDR_SCRATCH, d[7:0]);
    for (int i = 0; i < 2; i++) begin
      wr_reg(ADDR_LCTRL, 8'hbf);
      wr_reg(ADDR_FSC, {i[0], 7'h0});
      rd_reg(ADDR_DATA, i[0] ? tx_fifo_level_i : rx_fifo_level_i);
      wr_reg(ADDR_DATA, d[15:8] ^ 8'(i));
      chk("trigger", 16'(d[15:8] ^ 8'(i)), 16'(i[0] ? tx_trigger_o : rx_trigger_o));
    end
    wr_reg(ADDR_LCTRL, 8'h00);
    for (int c = 0; c < 16; c++) begin
      enh(ADDR_FSC, {6'h10, 2'(c)});
      wr_reg(ADDR_SCRATCH, {2'b00, 2'(c >> 2), 4'h0});
      @(posedge clk_sys_i);
      #1;
      chk("rts_hyst", 16'(hyst_tbl[c]), 16'(rts_hyst_o));
    end
    enh(ADDR_FSC, 8'h48);
    for (int k = 0; k < 4; k++) begin
      wr_reg(ADDR_SCRATCH, {4'h0, k[1], 3'h0});
      tx_active_i = k[0];
      @(posedge clk_sys_i);
      #1;
      chk("rs485_dir", 16'(!k[0] ^ k[1]), 16'(rs485_dir_o));
    end
    tx_active_i = 1'b0;
    wr_reg(ADDR_SCRATCH, 8'h04);
    chk("send_pending", 16'h1, 16'(send_pending_o));
    loads = 0;
    wr_reg(ADDR_DATA, d[7:0]);
    wr_reg(ADDR_DATA, d[15:8]);
    chk("direct_loads", 16'h1, 16'(loads));
    pulse(tx_byte_sent_i);
    chk("send_pending", 16'h0, 16'(send_pending_o));
    wr_reg(ADDR_SCRATCH, 8'h04);
    fifo_enabled_i = 1'b0;
    wr_reg(ADDR_DATA, d[7:0]);
    chk("direct_loads", 16'h1, 16'(loads));
    fifo_enabled_i = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr_reg(ADDR_SCRATCH, {m[1], m[0], 6'h0});
      pulse(xoff_seen_i);
      pulse(xon_seen_i);
      chk("xoff_xon", 16'({m[1], 1'b1}), 16'({xoff_irq_o, xon_irq_o}));
      pulse(special_seen_i);
      pulse(char_seen_i);
      chk("special", 16'(m[1]), 16'(special_irq_o));
      pulse(err_fifo_entry_i);
      chk("line_err", 16'(m[0]), 16'(line_err_irq_o));
      pulse(err_at_rhr_i);
      chk("line_err", 16'(!m[0]), 16'(line_err_irq_o));
      hb.access(ADDR_ISRC, 8'h00, 1'b0);
      chk("flags", 16'h0, 16'({xoff_irq_o, xon_irq_o, special_irq_o}));
    end
    wr_reg(ADDR_LCTRL, 8'h80);
    foreach (sels[k]) begin
      f = 4'($random(seed));
      d = 16'($random(seed));
      wr_reg(ADDR_FRAC, {sels[k], 2'b01, f});
      wr_reg(ADDR_DATA, d[7:0]);
      wr_reg(ADDR_DIV_HIGH, d[15:8]);
      if (sels[k] inside {2'b00, 2'b01}) {tdiv, tfr, ts} = {d, f, 2'b01};
      if (sels[k] inside {2'b00, 2'b11}) {rdiv, rfr, rs} = {d, f, 2'b01};
      chk("tx_div", tdiv, tx_divisor_o);
      chk("rx_div", rdiv, rx_divisor_o);
      chk("frac_samp", {4'h0, tfr, ts, rfr, rs},
        {4'h0, tx_fraction_o, tx_sampling_o, rx_fraction_o, rx_sampling_o});
      rd_reg(ADDR_DIV_HIGH, sels[k][1] ? rdiv[15:8] : tdiv[15:8]);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_FRAC, 8'(i << 4));
      e = (i > 1) ? 2'b10 : 2'(i);
      chk("sampling", {12'h0, e, e}, {12'h0, tx_sampling_o, rx_sampling_o});
    end
    wr_reg(ADDR_LCTRL, 8'hbf);
    wr_reg(ADDR_UNLOCK, 8'h00);
    wr_reg(ADDR_LCTRL, 8'h80);
    wr_reg(ADDR_FRAC, 8'h0f);
    chk("frac_locked", 16'h0, 16'(tx_fraction_o));
    wr_reg(ADDR_LCTRL, 8'h00);
    wr_reg(ADDR_FEATURE, 8'h10);
    chk("feat_locked", 16'h0, 16'(tx_disable_o));
    rst_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check_reset();
    wrap_up();
  end
endmodule
